// ===== rheo_pkg.sv
// Shared constants of the rheostat command interpreter.
package rheo_pkg;
   // Link and word widths.
   localparam int WORD_W = 16;
   localparam int DATA_W = 10;
   localparam int CMD_W = 4;
   localparam int CMD_LSB = 10;
   localparam int BYTE_BITS = 8;
   // Bus address: fixed prefix and the low pair per address pin state.
   localparam logic [4:0] ADDR_PREFIX = 5'h0b;
   localparam logic [1:0] ADDR_LO_GND = 2'h3;
   localparam logic [1:0] ADDR_LO_VDD = 2'h0;
   localparam logic [1:0] ADDR_LO_NC = 2'h2;
   // Command codes.
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WR_WIPER = 4'h1;
   localparam logic [3:0] CMD_RD_WIPER = 4'h2;
   localparam logic [3:0] CMD_STORE = 4'h3;
   localparam logic [3:0] CMD_SW_RESET = 4'h4;
   localparam logic [3:0] CMD_RD_OTP = 4'h5;
   localparam logic [3:0] CMD_RD_LAST = 4'h6;
   localparam logic [3:0] CMD_WR_CTRL = 4'h7;
   localparam logic [3:0] CMD_RD_CTRL = 4'h8;
   localparam logic [3:0] CMD_SHUTDOWN = 4'h9;
   // Control register bit positions.
   localparam int CTL_PROG_EN = 0;
   localparam int CTL_UNLOCK = 1;
   localparam int CTL_CAL_DIS = 2;
   localparam int CTL_SUCCESS = 3;
   localparam logic [2:0] CTRL_RST = 3'h0;
   // Wiper and memory.
   localparam logic [9:0] WIPER_MID = 10'h200;
   localparam logic [9:0] LOW_RES_MASK = 10'h3fc;
   localparam int OTP_DEPTH = 50;
   localparam logic [5:0] OTP_LAST_LOC = 6'h32;
   localparam logic [5:0] OTP_NONE = 6'h00;
   localparam logic [15:0] RDBK_RST = 16'h0000;
   // Store time and its cycle count at the 200 MHz clock.
   localparam int PROG_TIME_MS = 350;
   localparam int CLK_KHZ = 200000;
   localparam int PROG_CYCLES_DEF = PROG_TIME_MS * CLK_KHZ;
   localparam int BUSY_W = 27;
   // Synchroniser order {scl, sda, reset pin, addr level, addr float}.
   localparam logic [4:0] SYNC_RST = 5'h1c;
endpackage

// ===== rheostat_i2c_command_otp.sv
// Command interpreter of a single-channel rheostat with an I2C slave port.
`timescale 1ns/1ps
`default_nettype none
module rheostat_i2c_command_otp #(
   parameter bit LOW_RES = 1'b0,
   parameter int PROG_CYCLES = rheo_pkg::PROG_CYCLES_DEF
) (
   // Clock and power-up reset.
   input wire logic clk,
   input wire logic nrst,
   // I2C pins; the data pin is open drain.
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // Address strap and hardware reset pin.
   input wire logic addr_pin,
   input wire logic addr_float,
   input wire logic reset_pin_n,
   // Analog-side controls and status.
   output logic [rheo_pkg::DATA_W-1:0] wiper_code_register,
   output logic calibration_disable,
   output logic shutdown,
   output logic otp_busy
);
   import rheo_pkg::*;

   // Link states of the slave.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK_A = 3'b010,
      ST_WR = 3'b011,
      ST_ACK_W = 3'b100,
      ST_RD = 3'b101,
      ST_MACK = 3'b110
   } link_st_t;

   logic [4:0] sync1_q; // First synchroniser stage, read only by stage two.
   logic [4:0] sync2_q; // Second synchroniser stage.
   logic scl_prev_q; // Last synchronised clock level.
   logic sda_prev_q; // Last synchronised data level.
   logic hw_prev_q; // Last synchronised reset pin level.
   logic scl_s, sda_s, hw_s;
   logic scl_rise, scl_fall, start_det, stop_det, hw_fall;
   link_st_t st_q; // Link state.
   logic [3:0] cnt_q; // Bits seen in the current byte.
   logic [7:0] sh_q; // Receive shift register.
   logic [7:0] tx_q; // Transmit shift register.
   logic [7:0] hi_q; // Upper byte of the word in progress.
   logic byte_q; // Second byte of a word or of a read.
   logic rw_q; // Direction taken from the address byte.
   logic drive_q; // Data pin pulled low.
   logic mack_q; // Master acknowledged the last read byte.
   logic exec_q; // One-cycle command strobe.
   logic [WORD_W-1:0] word_q; // Command word to execute.
   logic [WORD_W-1:0] serial_readback_word; // Word for the next read.
   logic [2:0] ctrl_q; // Writable control bits.
   logic success_q; // Store success flag.
   logic [5:0] last_q; // Last programmed location, zero when none.
   logic [DATA_W-1:0] otp_wiper_memory [OTP_DEPTH]; // Fuse array model.
   logic [BUSY_W-1:0] busy_q; // Remaining store cycles.
   logic [1:0] addr_lo;
   logic addr_hit;
   logic [3:0] command_field;
   logic [DATA_W-1:0] cmd_data, wr_mask, stored_val, otp_sel_val;
   logic [5:0] sel;

   // Every pin is sampled twice before use, since it is asynchronous to clk.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end
      else
      begin
         sync1_q <= {scl, sda_i, reset_pin_n, addr_pin, addr_float};
         sync2_q <= sync1_q;
      end
   end

   assign scl_s = sync2_q[4];
   assign sda_s = sync2_q[3];
   assign hw_s = sync2_q[2];

   // Previous levels for edge detection on the synchronised copies.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         hw_prev_q <= 1'b1;
      end
      else
      begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         hw_prev_q <= hw_s;
      end
   end

   assign scl_rise = scl_s && !scl_prev_q;
   assign scl_fall = !scl_s && scl_prev_q;
   assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;
   assign hw_fall = hw_prev_q && !hw_s;

   // The pin state picks the low address pair; a floating pin wins.
   always_comb
   begin
      if (sync2_q[0])
      begin
         addr_lo = ADDR_LO_NC;
      end
      else if (sync2_q[1])
      begin
         addr_lo = ADDR_LO_VDD;
      end
      else
      begin
         addr_lo = ADDR_LO_GND;
      end
   end

   assign addr_hit = (sh_q[7:1] == {ADDR_PREFIX, addr_lo});
   assign otp_busy = (busy_q != '0);

   // Byte-level slave. Data changes only after a clock fall, so the pin is
   // stable while the master samples it high.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         hi_q <= 8'h00;
         byte_q <= 1'b0;
         rw_q <= 1'b0;
         drive_q <= 1'b0;
         mack_q <= 1'b0;
         exec_q <= 1'b0;
         word_q <= 16'h0000;
      end
      else
      begin
         exec_q <= 1'b0;
         if (start_det)
         begin
            // A start, repeated or not, always restarts the address phase.
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            byte_q <= 1'b0;
            drive_q <= 1'b0;
         end
         else if (stop_det)
         begin
            // A half-received word is dropped at stop.
            st_q <= ST_IDLE;
            drive_q <= 1'b0;
         end
         else
         begin
            unique case (st_q)
               ST_IDLE:
               begin
                  drive_q <= 1'b0;
               end
               ST_ADDR, ST_WR:
               begin
                  if (scl_rise)
                  begin
                     sh_q <= {sh_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end
                  else if (scl_fall && cnt_q == 4'(BYTE_BITS))
                  begin
                     cnt_q <= 4'h0;
                     if (otp_busy || (st_q == ST_ADDR && !addr_hit))
                     begin
                        // Busy or not ours: leave the pin released.
                        st_q <= ST_IDLE;
                     end
                     else
                     begin
                        drive_q <= 1'b1;
                        if (st_q == ST_ADDR)
                        begin
                           rw_q <= sh_q[0];
                           st_q <= ST_ACK_A;
                        end
                        else
                        begin
                           st_q <= ST_ACK_W;
                           hi_q <= sh_q;
                           byte_q <= !byte_q;
                           if (byte_q)
                           begin
                              // Each complete word runs in turn.
                              word_q <= {hi_q, sh_q};
                              exec_q <= 1'b1;
                           end
                        end
                     end
                  end
               end
               ST_ACK_A:
               begin
                  if (scl_fall)
                  begin
                     if (rw_q)
                     begin
                        tx_q <= serial_readback_word[15:8];
                        drive_q <= !serial_readback_word[15];
                        byte_q <= 1'b0;
                        st_q <= ST_RD;
                     end
                     else
                     begin
                        drive_q <= 1'b0;
                        byte_q <= 1'b0;
                        st_q <= ST_WR;
                     end
                  end
               end
               ST_ACK_W:
               begin
                  if (scl_fall)
                  begin
                     drive_q <= 1'b0;
                     st_q <= ST_WR;
                  end
               end
               ST_RD:
               begin
                  if (scl_rise)
                  begin
                     cnt_q <= cnt_q + 4'h1;
                  end
                  else if (scl_fall)
                  begin
                     if (cnt_q == 4'(BYTE_BITS))
                     begin
                        drive_q <= 1'b0;
                        st_q <= ST_MACK;
                     end
                     else
                     begin
                        tx_q <= {tx_q[6:0], 1'b1};
                        drive_q <= !tx_q[6];
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     mack_q <= !sda_s;
                  end
                  else if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     if (mack_q && !byte_q)
                     begin
                        tx_q <= serial_readback_word[7:0];
                        drive_q <= !serial_readback_word[7];
                        byte_q <= 1'b1;
                        st_q <= ST_RD;
                     end
                     else
                     begin
                        // No acknowledge, or both bytes sent: stay off the pin.
                        drive_q <= 1'b0;
                        st_q <= ST_IDLE;
                     end
                  end
               end
               default:
               begin
                  st_q <= ST_IDLE;
                  drive_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open drain: the driven level is always low.
   assign sda_o = 1'b0;
   assign sda_oe_n = !drive_q;

   // Command decode; the two spare leading bits are not looked at.
   assign command_field = word_q[CMD_LSB +: CMD_W];
   assign wr_mask = LOW_RES ? LOW_RES_MASK : '1;
   assign cmd_data = word_q[DATA_W-1:0] & wr_mask;
   assign sel = word_q[5:0];
   // Last stored code, or midscale when nothing was stored.
   assign stored_val = (last_q == OTP_NONE) ? WIPER_MID :
      otp_wiper_memory[last_q - 6'h1];
   assign otp_sel_val = (sel == OTP_NONE || sel > OTP_LAST_LOC) ? '0 :
      otp_wiper_memory[sel - 6'h1];

   // Wiper code: write when unlocked, refresh by command or reset pin.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         wiper_code_register <= WIPER_MID;
      end
      else if (hw_fall)
      begin
         wiper_code_register <= stored_val;
      end
      else if (exec_q && !otp_busy)
      begin
         if (command_field == CMD_WR_WIPER && ctrl_q[CTL_UNLOCK])
         begin
            wiper_code_register <= cmd_data;
         end
         else if (command_field == CMD_SW_RESET)
         begin
            wiper_code_register <= stored_val;
         end
      end
   end

   // Control bits and shutdown.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrl_q <= CTRL_RST;
         shutdown <= 1'b0;
      end
      else if (exec_q && !otp_busy)
      begin
         if (command_field == CMD_WR_CTRL)
         begin
            ctrl_q <= word_q[2:0];
         end
         else if (command_field == CMD_SHUTDOWN)
         begin
            shutdown <= word_q[0];
         end
      end
   end

   assign calibration_disable = ctrl_q[CTL_CAL_DIS];

   // Store engine: one location per store, then a long lock-out.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         last_q <= OTP_NONE;
         success_q <= 1'b0;
         busy_q <= '0;
         for (int i = 0; i < OTP_DEPTH; i++)
         begin
            otp_wiper_memory[i] <= '0;
         end
      end
      else if (otp_busy)
      begin
         busy_q <= busy_q - BUSY_W'(1);
      end
      else if (exec_q && command_field == CMD_STORE)
      begin
         if (ctrl_q[CTL_PROG_EN] && last_q < OTP_LAST_LOC)
         begin
            otp_wiper_memory[last_q] <= wiper_code_register;
            last_q <= last_q + 6'h1;
            success_q <= 1'b1;
            busy_q <= BUSY_W'(PROG_CYCLES);
         end
         else
         begin
            // Disabled or full: nothing burns and the flag reads failure.
            success_q <= 1'b0;
         end
      end
   end

   // Readback word; only read commands change it, so a nop keeps it.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         serial_readback_word <= RDBK_RST;
      end
      else if (exec_q && !otp_busy)
      begin
         unique case (command_field)
            CMD_RD_WIPER:
            begin
               serial_readback_word <= {6'h00, wiper_code_register & wr_mask};
            end
            CMD_RD_OTP:
            begin
               serial_readback_word <= {6'h00, otp_sel_val};
            end
            CMD_RD_LAST:
            begin
               serial_readback_word <= {10'h000, last_q};
            end
            CMD_RD_CTRL:
            begin
               serial_readback_word <= {12'h000, success_q, ctrl_q};
            end
            default:
            begin
               // Writes, nop and undefined codes leave it alone.
               serial_readback_word <= serial_readback_word;
            end
         endcase
      end
   end
endmodule // rheostat_i2c_command_otp
`default_nettype wire

// ===== rheostat_i2c_command_otp_checker.sv
// Port-level assertions for the rheostat command interpreter.
`timescale 1ns/1ps
`default_nettype none
module rheostat_i2c_command_otp_checker #(
   parameter int PROG_CYCLES = 200
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Link, strap and reset pins.
   input wire logic scl,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic addr_pin,
   input wire logic addr_float,
   input wire logic reset_pin_n,
   // Analog-side outputs.
   input wire logic [rheo_pkg::DATA_W-1:0] wiper_code_register,
   input wire logic calibration_disable,
   input wire logic shutdown,
   input wire logic otp_busy
);
   import rheo_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   int busy_cnt_q; // Length of the running lock-out.
   logic [DATA_W-1:0] stored_q; // Last wiper value sent to memory.
   // Count busy cycles; cleared when idle so each stretch is measured alone.
   always_ff @(posedge clk)
   begin
      busy_cnt_q <= (!nrst || !otp_busy) ? 0 : busy_cnt_q + 1;
   end
   // Capture the stored code when a store starts, since reloads must return it.
   always_ff @(posedge clk)
   begin
      if (!nrst)
         stored_q <= WIPER_MID;
      else if ($rose(otp_busy))
         stored_q <= wiper_code_register;
   end
   property p_reset_vals;
      $rose(nrst) |-> wiper_code_register == WIPER_MID && !shutdown && !otp_busy && sda_oe_n;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
   property p_pull_low;
      !sda_oe_n |-> sda_o == 1'b0;
   endproperty
   a_pull_low: assert property (p_pull_low) else $error("drive level high");
   property p_stands;
      scl && $past(scl) && $past(scl, 2) && $past(scl, 3) |-> $stable(sda_oe_n);
   endproperty
   a_stands: assert property (p_stands) else $error("data moved in clock high");
   property p_busy_nack;
      otp_busy && $past(otp_busy, 16) |-> sda_oe_n;
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("drive while busy");
   property p_busy_len;
      $fell(otp_busy) |-> busy_cnt_q == PROG_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_busy_freeze;
      otp_busy |=> $stable(shutdown) && $stable(calibration_disable);
   endproperty
   a_busy_freeze: assert property (p_busy_freeze) else $error("change while busy");
   property p_store_ack;
      $rose(otp_busy) |-> !sda_oe_n;
   endproperty
   a_store_ack: assert property (p_store_ack) else $error("store off the ack");
   property p_pin_reload;
      $fell(reset_pin_n) |-> ##[3:8] wiper_code_register == stored_q;
   endproperty
   a_pin_reload: assert property (p_pin_reload) else $error("pin reload wrong");
endmodule // rheostat_i2c_command_otp_checker
bind rheostat_i2c_command_otp rheostat_i2c_command_otp_checker #(
   .PROG_CYCLES(PROG_CYCLES)
) chk_u (
   .clk(clk), .nrst(nrst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
   .addr_pin(addr_pin), .addr_float(addr_float), .reset_pin_n(reset_pin_n),
   .wiper_code_register(wiper_code_register), .calibration_disable(calibration_disable),
   .shutdown(shutdown), .otp_busy(otp_busy));
`default_nettype wire

// ===== i2c_master_model.sv
// Behavioural I2C bus master facing the rheostat link.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   // Clock pin, held high between frames.
   output logic scl,
   // Data drive: 0 pulls low, 1 releases to the pull-up.
   output logic sda_m,
   // Resolved data line.
   input wire logic sda
);
   localparam time QTR = 12; // Quarter of the 48 ns link clock.
   // Both lines idle high from time zero.
   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // One pulse: data set mid-low, sampled at the rising edge.
   task automatic bit_x(input logic b, output logic r);
      #QTR sda_m = b;
      #QTR scl = 1'b1;
      r = sda;
      #(2 * QTR) scl = 1'b0;
   endtask
   task automatic start();
      #QTR sda_m = 1'b0;
      #QTR scl = 1'b0;
   endtask
   task automatic stop();
      #QTR sda_m = 1'b0;
      #QTR scl = 1'b1;
      #QTR sda_m = 1'b1;
      #QTR;
   endtask
   // Sends a byte MSB first and returns whether the device pulled the ninth bit low.
   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = !r;
   endtask
   // Reads a byte with the line released; last set means no acknowledge.
   task automatic byte_r(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, d[i]);
      bit_x(last, r);
   endtask
   // Write transfer of n words, first word in the highest used bytes of ws.
   task automatic wr(input logic [6:0] a, input logic [31:0] ws, input int n, output logic ok);
      logic ak;
      start();
      byte_w({a, 1'b0}, ok);
      for (int j = 2 * n - 1; j >= 0; j--)
      begin
         byte_w(ws[j*8 +: 8], ak);
         ok = ok & ak;
      end
      stop();
   endtask
   // Read transfer; with nack1 the second byte is probed with the line released.
   task automatic rd(input logic [6:0] a, input logic nack1, output logic [15:0] v,
                     output logic ok);
      start();
      byte_w({a, 1'b1}, ok);
      byte_r(nack1, v[15:8]);
      byte_r(1'b1, v[7:0]);
      stop();
   endtask
endmodule // i2c_master_model
`default_nettype wire

// ===== rheostat_i2c_command_otp_tb.sv
// Self-checking testbench of the rheostat command interpreter.
`timescale 1ns/1ps
`default_nettype none
module rheostat_i2c_command_otp_tb;
   import rheo_pkg::*;
   localparam int PCYC = 200; // Short store time keeps the run brief.
   logic clk, nrst, scl, sda_m, sda_o, sda_oe_n, addr_pin, addr_float, reset_pin_n;
   logic cal_dis, shut, busy;
   logic [DATA_W-1:0] wiper;
   logic sda_o2, sda_oe_n2; // Data pin drive of the low-resolution instance.
   logic [DATA_W-1:0] wiper2; // Wiper code of the low-resolution instance.
   logic [6:0] dev; // Address with the strap left open.
   wire sda;
   int n_mismatch, num_checks;
   // Open-drain line with pull-up: low when the master or either device pulls.
   assign sda = sda_m & (sda_oe_n | sda_o) & (sda_oe_n2 | sda_o2);
   rheostat_i2c_command_otp #(.LOW_RES(1'b0), .PROG_CYCLES(PCYC)) dut_u (
      .clk(clk), .nrst(nrst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .addr_pin(addr_pin), .addr_float(addr_float), .reset_pin_n(reset_pin_n),
      .wiper_code_register(wiper), .calibration_disable(cal_dis), .shutdown(shut),
      .otp_busy(busy));
   // A second, low-resolution device on the same bus, strapped to the supply address.
   rheostat_i2c_command_otp #(.LOW_RES(1'b1), .PROG_CYCLES(PCYC)) dut_low_u (
      .clk(clk), .nrst(nrst), .scl(scl), .sda_i(sda), .sda_o(sda_o2), .sda_oe_n(sda_oe_n2),
      .addr_pin(1'b1), .addr_float(1'b0), .reset_pin_n(reset_pin_n),
      .wiper_code_register(wiper2), .calibration_disable(), .shutdown(),
      .otp_busy());
   i2c_master_model m_u (.scl(scl), .sda_m(sda_m), .sda(sda));
   // 200 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic summarize();
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [3:0] c, input logic [9:0] d, output logic ok);
      m_u.wr(dev, {18'h0, c, d}, 1, ok);
   endtask
   task automatic getw(input logic [3:0] c, input logic [9:0] d, output logic [15:0] v);
      logic ok;
      cmd(c, d, ok);
      m_u.rd(dev, 1'b0, v, ok);
   endtask
   // Bounded wait for the store lock-out to end.
   task automatic wait_idle();
      for (int i = 0; i < 4 * PCYC && busy !== 1'b0; i++)
         @(negedge clk);
      chk("busy", 16'h0, {15'h0, busy});
      if (busy !== 1'b0)
         summarize();
   endtask
   // Each strap setting answers its own address and ignores a neighbour.
   task automatic t_addr();
      logic ok;
      logic [1:0] lo [3];
      lo = '{ADDR_LO_VDD, ADDR_LO_GND, ADDR_LO_NC};
      for (int i = 0; i < 3; i++)
      begin
         @(negedge clk);
         addr_pin = (i == 0);
         addr_float = (i == 2);
         repeat (4) @(negedge clk);
         m_u.wr({ADDR_PREFIX, lo[i]}, 32'h0, 1, ok);
         chk("own address ack", 16'h1, {15'h0, ok});
         m_u.wr({ADDR_PREFIX, lo[i] ^ 2'h1}, 32'h0, 1, ok);
         chk("foreign address ack", 16'h0, {15'h0, ok});
      end
   endtask
   // Locked wiper, unlock plus write in one transfer, readbacks, refused second byte.
   task automatic t_protect();
      logic ok;
      logic [15:0] v;
      cmd(CMD_WR_WIPER, 10'h155, ok);
      chk("locked wiper", 16'h0200, {6'h0, wiper});
      m_u.wr(dev, {2'b00, CMD_WR_CTRL, 10'h003, 2'b00, CMD_WR_WIPER, 10'h2c5}, 2, ok);
      chk("two-word ack", 16'h1, {15'h0, ok});
      chk("wiper", 16'h02c5, {6'h0, wiper});
      getw(CMD_RD_WIPER, 10'h0, v);
      chk("wiper readback", 16'h02c5, v);
      getw(CMD_RD_CTRL, 10'h0, v);
      chk("ctrl readback", 16'h0003, v);
      m_u.rd(dev, 1'b1, v, ok);
      chk("byte after nack", 16'h00ff, {8'h0, v[7:0]});
   endtask
   // Two stores, lock-out, index, contents, success flag and both reloads.
   task automatic t_store();
      logic ok;
      logic [15:0] v;
      cmd(CMD_WR_WIPER, 10'h100, ok);
      cmd(CMD_STORE, 10'h0, ok);
      chk("busy after store", 16'h1, {15'h0, busy});
      cmd(CMD_NOP, 10'h0, ok);
      chk("poll while busy", 16'h0, {15'h0, ok});
      wait_idle();
      getw(CMD_RD_LAST, 10'h0, v);
      chk("last location", 16'h0001, v);
      getw(CMD_RD_CTRL, 10'h0, v);
      chk("ctrl after store", 16'h000b, v);
      getw(CMD_RD_OTP, 10'h001, v);
      chk("location 1", 16'h0100, v);
      cmd(CMD_WR_WIPER, 10'h0aa, ok);
      cmd(CMD_STORE, 10'h0, ok);
      wait_idle();
      getw(CMD_RD_LAST, 10'h0, v);
      chk("next location", 16'h0002, v);
      cmd(CMD_WR_WIPER, 10'h3ff, ok);
      cmd(CMD_SW_RESET, 10'h0, ok);
      chk("soft reload", 16'h00aa, {6'h0, wiper});
      cmd(CMD_WR_WIPER, 10'h000, ok);
      chk("terminal a", 16'h0000, {6'h0, wiper});
      @(negedge clk);
      reset_pin_n = 1'b0;
      repeat (4) @(negedge clk);
      reset_pin_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("pin reload", 16'h00aa, {6'h0, wiper});
   endtask
   // Shutdown both ways, calibration bit, undefined codes, refused store.
   task automatic t_misc();
      logic ok;
      logic [15:0] v;
      for (int i = 1; i >= 0; i--)
      begin
         cmd(CMD_SHUTDOWN, 10'(i), ok);
         chk("shutdown", 16'(i), {15'h0, shut});
      end
      cmd(CMD_WR_CTRL, 10'h006, ok);
      chk("cal disable", 16'h1, {15'h0, cal_dis});
      for (int c = 10; c < 16; c++)
         cmd(4'(c), 10'h3ff, ok);
      chk("after undefined", 16'h08aa, {4'h0, cal_dis, shut, wiper});
      cmd(CMD_STORE, 10'h0, ok);
      chk("disabled store", 16'h0, {15'h0, busy});
      getw(CMD_RD_CTRL, 10'h0, v);
      chk("ctrl after refusal", 16'h0006, v);
   endtask
   // The low-resolution device drops the two lowest data bits of a wiper write.
   task automatic t_lowres();
      logic ok;
      logic [15:0] v;
      dev = {ADDR_PREFIX, ADDR_LO_VDD};
      cmd(CMD_WR_CTRL, 10'h002, ok);
      cmd(CMD_WR_WIPER, 10'h2c7, ok);
      chk("low-res wiper", 16'h02c4, {6'h0, wiper2});
      getw(CMD_RD_WIPER, 10'h0, v);
      chk("low-res readback", 16'h02c4, v);
      dev = {ADDR_PREFIX, ADDR_LO_NC};
   endtask
   initial
   begin
      n_mismatch = 0;
      num_checks = 0;
      dev = {ADDR_PREFIX, ADDR_LO_NC};
      nrst = 1'b0;
      addr_pin = 1'b0;
      addr_float = 1'b1;
      reset_pin_n = 1'b1;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      chk("reset wiper", 16'h0200, {6'h0, wiper});
      chk("reset flags", 16'h0, {13'h0, cal_dis, shut, busy});
      t_addr();
      t_protect();
      t_store();
      t_misc();
      t_lowres();
      summarize();
   end
endmodule // rheostat_i2c_command_otp_tb
`default_nettype wire
